/* bench/cmc_can_node.sv */
// Behavioural CAN bus node: bit clock, frames, wired-AND bus level
`timescale 1ns/1ps
module cmc_can_node #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic tx_pin_in,
  output logic      bit_tick_out,
  output logic      bus_rx_out,
  output logic      rx_busy_out,
  output logic      rx_done_out,
  output logic      msg_ack_out
);
  logic dom  = 1'b0;
  logic fbit = 1'b1;
  int   cnt;

  // Quiet bus at time zero
  initial begin
    rx_busy_out = 1'b0;
    rx_done_out = 1'b0;
    msg_ack_out = 1'b0;
  end

  // Dominant wins; an idle bus floats back to recessive
  assign bus_rx_out = ~dom & fbit & tx_pin_in;

  // Bit time base, one tick per bit
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 0;
      bit_tick_out <= 1'b0;
    end else begin
      cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
      bit_tick_out <= (cnt == BIT_CYC - 1);
    end
  end

  // One frame, first bit dominant; length sets a fast or slow answer
  task automatic frame(input int nbits);
    rx_busy_out <= 1'b1;
    for (int i = 0; i < nbits; i++) begin
      fbit <= i[0];
      @(posedge clk_in iff bit_tick_out);
    end
    fbit <= 1'b1;
    rx_busy_out <= 1'b0;
    rx_done_out <= 1'b1;
    msg_ack_out <= 1'b1;
    @(posedge clk_in);
    rx_done_out <= 1'b0;
    msg_ack_out <= 1'b0;
  endtask
endmodule

/* bench/test_can_mode_control_register.sv */
// Self-checking bench of the CAN mode control block
`timescale 1ns/1ps
`define CHK(n, g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); \
  end \
end
module test_can_mode_control_register;
  import cmc_pkg::*;
  logic        clk_in, sys_rst_in = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        tx_empty = 1'b1, tx_bit = 1'b1, wflag = 1'b0;
  logic        boff = 1'b0, cw = 1'b0, cs = 1'b0;
  logic [3:0]  addr = 4'h0, saddr;
  logic [7:0]  wdata = 8'h00, rdata, sdata;
  logic        tick, rxd, busy, done, ack, txp, abrt, ini, cfgok, bif;
  logic        wev, swe;
  logic        m_time = 1'b0;
  logic [31:0] lfsr = 32'hFD913508;
  logic [11:0] exp_q[$], got_q[$];
  int          n_mismatch = 0, n_compared = 0, cyc = 0;
  int          m_cnt = 0, n_wake = 0;

  cmc_mode_ctrl DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_frame_done_in(done),
    .rx_busy_in(busy), .tx_bufs_empty_in(tx_empty), .tx_bit_in(tx_bit),
    .bit_tick_in(tick), .msg_ack_in(ack), .wake_flag_in(wflag),
    .bus_off_in(boff), .cpu_wait_in(cw), .cpu_stop_in(cs),
    .bus_rx_pin_in(rxd), .transmit_pin_out(txp), .abort_xfer_out(abrt),
    .init_reset_out(ini), .cfg_write_ok_out(cfgok),
    .bif_clk_run_out(bif), .wake_event_out(wev), .stamp_we_out(swe),
    .stamp_addr_out(saddr), .stamp_data_out(sdata));

  cmc_can_node #(.BIT_CYC(8)) nd (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .tx_pin_in(txp), .bit_tick_out(tick),
    .bus_rx_out(rxd), .rx_busy_out(busy), .rx_done_out(done),
    .msg_ack_out(ack));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Stamp counter model, stamp capture and hang guard
  always @(posedge clk_in) begin
    if (!m_time) m_cnt <= 0;
    else if (tick) m_cnt <= m_cnt + 1;
    if (ack && m_time) begin
      exp_q.push_back({STAMP_HI_OFS, m_cnt[15:8]});
      exp_q.push_back({STAMP_LO_OFS, m_cnt[7:0]});
    end
    if (swe === 1'b1) got_q.push_back({saddr, sdata});
    if (wev === 1'b1) n_wake++;
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_in iff tick);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    if (a === ADDR_MODE && ini === 1'b0) m_time <= d[B_TIME];
  endtask

  task automatic rd_chk(input string n, input logic [3:0] a,
                        input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 `CHK(n, rdata & m, e & m)
  endtask

  // Leave init over a dominant bus, then count recessive runs
  task automatic resync_chk(input int runs, input logic [7:0] d,
                            input logic [7:0] e);
    nd.dom <= 1'b1;
    tk(2);
    wr_reg(ADDR_MODE, d);
    tk(2);
    nd.dom <= 1'b0;
    tk(runs * 11 - 1);
    rd_chk("sync early", ADDR_MODE, e & 8'hEF, 8'hFF);
    tk(1);
    rd_chk("sync", ADDR_MODE, e, 8'hFF);
  endtask

  task automatic stamp_chk();
    logic [11:0] g, e;
    repeat (4) @(posedge clk_in);
    `CHK("stamp n", got_q.size(), 2)
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      g = (got_q.size() > 0) ? got_q.pop_front() : 12'h000;
      `CHK("stamp", g, e)
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // Reset leaves the block in init mode
    #1 `CHK("tx pin", txp, 1'b1)
    `CHK("init", ini, 1'b1)
    `CHK("cfg ok", cfgok, 1'b1)
    `CHK("abort", abrt, 1'b1)
    rd_chk("mode rst", ADDR_MODE, MODE_RST, 8'hFF);
    rd_chk("ack rst", ADDR_ACK, 8'h01, 8'hFF);
    lfsr = nxt(lfsr);
    wr_reg(ADDR_MODE, lfsr[7:0] | 8'h01);
    rd_chk("init hold", ADDR_MODE, 8'h01, 8'hFF);
    wr_reg(ADDR_ACK, 8'hFF);
    wr_reg(4'h7, 8'hFF);
    rd_chk("ack ro", ADDR_ACK, 8'h01, 8'hFF);
    rd_chk("unmapped", 4'h7, 8'h00, 8'hFF);
    resync_chk(1, 8'h00, 8'h10);
    rd_chk("ack run", ADDR_ACK, 8'h00, 8'hFF);
    `CHK("init off", ini, 1'b0)
    `CHK("cfg shut", cfgok, 1'b0)
    `CHK("abort off", abrt, 1'b0)
    // Reception status and sticky frame flag
    fork
      nd.frame(20);
      begin
        tk(5);
        rd_chk("rx act", ADDR_MODE, 8'h50, 8'hFF);
      end
    join
    rd_chk("rx flag", ADDR_MODE, 8'h90, 8'hFF);
    wr_reg(ADDR_MODE, 8'h00);
    rd_chk("w0 keeps", ADDR_MODE, 8'h90, 8'hFF);
    wr_reg(ADDR_MODE, 8'h80);
    rd_chk("w1 clr", ADDR_MODE, 8'h10, 8'hFF);
    `CHK("no stamp", got_q.size(), 0)
    exp_q.delete();
    // Time stamps at random counts, then after a disable
    lfsr = nxt(lfsr);
    wr_reg(ADDR_MODE, 8'h08);
    tk(260 + lfsr[5:0]);
    nd.frame(8 + lfsr[8:6]);
    stamp_chk();
    wr_reg(ADDR_MODE, 8'h00);
    wr_reg(ADDR_MODE, 8'h08);
    nd.frame(9);
    stamp_chk();
    wr_reg(ADDR_MODE, 8'h80);
    // Wait and stop gating of bus interface and transmit pin
    @(posedge clk_in);
    tx_bit <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 `CHK("tx follow", txp, 1'b0)
    wr_reg(ADDR_MODE, 8'h20);
    cw <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 `CHK("bif halt", bif, 1'b0)
    `CHK("tx wait", txp, 1'b1)
    rd_chk("rd halt", ADDR_MODE, 8'h00, 8'hFF);
    @(posedge clk_in);
    cw <= 1'b0;
    wr_reg(ADDR_MODE, 8'h00);
    cw <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 `CHK("bif run", bif, 1'b1)
    `CHK("tx run", txp, 1'b0)
    @(posedge clk_in);
    cw <= 1'b0;
    cs <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 `CHK("tx stop", txp, 1'b1)
    @(posedge clk_in);
    cs <= 1'b0;
    tx_bit <= 1'b1;
    // Sleep handshake, refusals and wake-up
    wflag <= 1'b1;
    wr_reg(ADDR_MODE, 8'h06);
    rd_chk("slp refused", ADDR_MODE, 8'h14, 8'hFF);
    @(posedge clk_in);
    wflag <= 1'b0;
    tx_empty <= 1'b0;
    wr_reg(ADDR_MODE, 8'h06);
    rd_chk("slp wait", ADDR_ACK, 8'h00, 8'hFF);
    wr_reg(ADDR_MODE, 8'h04);
    rd_chk("clr early", ADDR_MODE, 8'h06, 8'h0F);
    @(posedge clk_in);
    tx_empty <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd_chk("slp ack", ADDR_ACK, 8'h02, 8'hFF);
    n_wake = 0;
    nd.frame(14);
    tk(12);
    `CHK("wake", n_wake, 1)
    rd_chk("woke", ADDR_MODE, 8'h14, 8'h7F);
    rd_chk("ack woke", ADDR_ACK, 8'h00, 8'hFF);
    wr_reg(ADDR_MODE, 8'h82);
    repeat (2) @(posedge clk_in);
    rd_chk("slp2", ADDR_ACK, 8'h02, 8'hFF);
    nd.frame(6);
    rd_chk("no wake", ADDR_ACK, 8'h02, 8'hFF);
    wr_reg(ADDR_MODE, 8'h80);
    tk(12);
    rd_chk("slp left", ADDR_MODE, 8'h10, 8'hFF);
    // Init re-entry with an early clear, then bus-off recovery
    @(posedge clk_in);
    tx_bit <= 1'b0;
    addr <= ADDR_MODE;
    wdata <= 8'h0D;
    wr <= 1'b1;
    @(posedge clk_in);
    wdata <= 8'h04;
    @(posedge clk_in);
    wr <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 `CHK("tx init", txp, 1'b1)
    rd_chk("init again", ADDR_MODE, 8'h05, 8'hFF);
    rd_chk("clr ignored", ADDR_ACK, 8'h01, 8'hFF);
    @(posedge clk_in);
    tx_bit <= 1'b1;
    boff <= 1'b1;
    resync_chk(128, 8'h04, 8'h14);
    @(posedge clk_in);
    boff <= 1'b0;
    end_of_test();
  end
endmodule

/* rtl/cmc_mode_ctrl.sv */
// CAN mode control register with sleep, init and resync handling
//
// Contract
// RULE_01: Received frame flag sets on any valid reception, sticky until cleared.
// RULE_02: Received frame flag clears only by writing one; zero is ignored.
// RULE_03: Receiver active reads high while receiving, low when sending or idle.
// RULE_04: Stop in wait halts the processor bus interface during wait.
// RULE_05: Bus synchronized is read-only, owned by the block.
// RULE_06: Stamp enable runs a 16-bit counter at bit clock rate.
// RULE_07: On acknowledge the counter goes to the top two buffer bytes.
// RULE_08: Stamp counter is zero whenever stamp enable is zero.
// RULE_09: Stamp enable is held zero in initialization mode.
// RULE_10: Wake enable lets bus traffic end sleep; set it before sleeping.
// RULE_11: Sleep is entered only with no reception and empty transmit buffers.
// RULE_12: Sleep acknowledge shows completed sleep entry.
// RULE_13: Sleep request cannot be set while the wake flag is set.
// RULE_14: Sleep lasts until software clears request or wake clears it.
// RULE_15: Init request aborts transfers, drops sync, enters init, then acks.
// RULE_16: Entering init resets the listed registers, keeping noted bits.
// RULE_17: Configuration registers are writable only in init mode.
// RULE_18: Error counters are untouched by entering or leaving init.
// RULE_19: After init outside bus-off, sync follows 11 recessive bits.
// RULE_20: In bus-off, sync follows 128 runs of 11 recessive bits.
// RULE_21: Software writes other control bits only after init is fully left; the code accepts them unless init request and init acknowledge are both set.
// RULE_22: Software clear of sleep request ignored until sleep acknowledged.
// RULE_23: Software clear of init request ignored until init acknowledged.
// RULE_24: Transmit pin forced recessive on init request or halting wait/stop.
`timescale 1ns/1ps
module cmc_mode_ctrl (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       rx_frame_done_in,
  input  wire logic       rx_busy_in,
  input  wire logic       tx_bufs_empty_in,
  input  wire logic       tx_bit_in,
  input  wire logic       bit_tick_in,
  input  wire logic       msg_ack_in,
  input  wire logic       wake_flag_in,
  input  wire logic       bus_off_in,
  input  wire logic       cpu_wait_in,
  input  wire logic       cpu_stop_in,
  input  wire logic       bus_rx_pin_in,
  output logic            transmit_pin_out,
  output logic            abort_xfer_out,
  output logic            init_reset_out,
  output logic            cfg_write_ok_out,
  output logic            bif_clk_run_out,
  output logic            wake_event_out,
  output logic            stamp_we_out,
  output logic      [3:0] stamp_addr_out,
  output logic      [7:0] stamp_data_out
);
  import cmc_pkg::*;

  // Pin synchronizer; only the second stage reads the first
  logic [2:0] rx_sync_q;
  logic       rx_level_q;
  logic       rx_level_d;
  // Control bits
  logic received_frame_flag_q, received_frame_flag_d, stopw_q, stopw_d, time_q, time_d;
  logic wake_q, wake_d, sleep_request_q, sleep_request_d, config_mode_request_q, config_mode_request_d;
  // Mode state and resync counters
  cmc_state_t state_q, state_d;
  logic [3:0]  rec_cnt_q, rec_cnt_d;
  logic [7:0]  run_cnt_q, run_cnt_d;
  logic [15:0] stamp_q, stamp_d;
  // Stamp store sequencer
  logic        beat_q, beat_d;
  logic [7:0]  lo_byte_q, lo_byte_d;
  logic        st_we_q, st_we_d;
  logic [3:0]  st_addr_q, st_addr_d;
  logic [7:0]  st_data_q, st_data_d;
  // Outputs held in flip-flops
  logic [7:0]  rdata_q, rdata_d;
  logic        txpin_q, txpin_d;
  logic        wake_ev_q, wake_ev_d;
  // Decodes
  logic bif_run, init_mode, cfg_ack, slp_ack, wr_mode, halt_tx;
  logic bus_idle, wake_hit;

  // Bus interface stops in wait when asked, saving power
  assign bif_run   = !(cpu_wait_in && stopw_q);            // [RULE_04]
  assign cfg_ack   = (state_q == ST_INIT);
  assign slp_ack   = (state_q == ST_SLEEP);                // [RULE_12]
  assign init_mode = config_mode_request_q && cfg_ack;
  assign wr_mode   = reg_wr_in && bif_run && (reg_addr_in == ADDR_MODE);
  assign bus_idle  = !rx_busy_in && tx_bufs_empty_in;
  assign wake_hit  = wake_q && !rx_level_q;
  assign halt_tx   = config_mode_request_q || cpu_stop_in
                   || (cpu_wait_in && stopw_q);
  assign abort_xfer_out   = config_mode_request_q;                      // [RULE_15]
  assign init_reset_out   = init_mode;                     // [RULE_16]
  assign cfg_write_ok_out = init_mode;                     // [RULE_17]
  assign bif_clk_run_out  = bif_run;
  assign reg_rdata_out    = rdata_q;
  assign transmit_pin_out = txpin_q;
  assign wake_event_out   = wake_ev_q;
  assign stamp_we_out     = st_we_q;
  assign stamp_addr_out   = st_addr_q;
  assign stamp_data_out   = st_data_q;

  // Pin level changes only once stages two and three agree
  always_comb begin
    rx_level_d = rx_level_q;
    if (rx_sync_q[1] == rx_sync_q[2]) begin
      rx_level_d = rx_sync_q[2];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_sync_q  <= 3'h7;
      rx_level_q <= 1'b1;
    end else begin
      rx_sync_q  <= {rx_sync_q[1:0], bus_rx_pin_in};
      rx_level_q <= rx_level_d;
    end
  end

  // Control bits; hardware set wins over software clear
  always_comb begin
    received_frame_flag_d  = received_frame_flag_q;
    stopw_d  = stopw_q;
    time_d   = time_q;
    wake_d   = wake_q;
    sleep_request_d  = sleep_request_q;
    config_mode_request_d = config_mode_request_q;
    // Other control bits are locked while in init mode
    if (wr_mode && !init_mode) begin                       // [RULE_16]
      stopw_d = reg_wdata_in[B_STOPW];
      time_d  = reg_wdata_in[B_TIME];
      wake_d  = reg_wdata_in[B_WAKE];                      // [RULE_10]
      if (reg_wdata_in[B_RECEIVED_FRAME_FLAG]) begin
        received_frame_flag_d = 1'b0;                                    // [RULE_02]
      end
      if (reg_wdata_in[B_SLEEP_REQUEST] && !wake_flag_in) begin
        sleep_request_d = 1'b1;                                    // [RULE_13]
      end else if (!reg_wdata_in[B_SLEEP_REQUEST] && slp_ack) begin
        sleep_request_d = 1'b0;                                    // [RULE_22]
      end
    end
    if (wr_mode) begin
      if (reg_wdata_in[B_INIT]) begin
        config_mode_request_d = 1'b1;
      end else if (cfg_ack) begin
        config_mode_request_d = 1'b0;                                   // [RULE_23]
      end
    end
    // Bus activity ends sleep only when enabled
    if (slp_ack && wake_hit) begin
      sleep_request_d = 1'b0;                                      // [RULE_14]
    end
    if (rx_frame_done_in) begin
      received_frame_flag_d = 1'b1;                                      // [RULE_01]
    end
    // Init holds these at reset value, wake and requests kept
    if (init_mode) begin
      received_frame_flag_d = 1'b0;                                      // [RULE_16]
      stopw_d = 1'b0;
      time_d  = 1'b0;                                      // [RULE_09]
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      received_frame_flag_q  <= MODE_RST[B_RECEIVED_FRAME_FLAG];
      stopw_q  <= MODE_RST[B_STOPW];
      time_q   <= MODE_RST[B_TIME];
      wake_q   <= MODE_RST[B_WAKE];
      sleep_request_q  <= MODE_RST[B_SLEEP_REQUEST];
      config_mode_request_q <= MODE_RST[B_INIT];
    end else begin
      received_frame_flag_q  <= received_frame_flag_d;
      stopw_q  <= stopw_d;
      time_q   <= time_d;
      wake_q   <= wake_d;
      sleep_request_q  <= sleep_request_d;
      config_mode_request_q <= config_mode_request_d;
    end
  end

  // Mode state machine; init request outranks everything
  always_comb begin
    state_d   = state_q;
    rec_cnt_d = rec_cnt_q;
    run_cnt_d = run_cnt_q;
    wake_ev_d = 1'b0;
    case (state_q)
      ST_RESYNC: begin
        if (sleep_request_q && bus_idle) begin
          state_d = ST_SLEEP;                              // [RULE_11]
        end else if (bit_tick_in && !rx_level_q) begin
          rec_cnt_d = 4'h0;
        end else if (bit_tick_in) begin
          rec_cnt_d = rec_cnt_q + 4'h1;
          if (rec_cnt_d == REC_RUN) begin
            rec_cnt_d = 4'h0;
            run_cnt_d = run_cnt_q + 8'h01;
            // Bus-off needs many idle runs before rejoining
            if (!bus_off_in || run_cnt_d == BOFF_RUNS) begin
              state_d = ST_RUN;                            // [RULE_19] [RULE_20]
            end
          end
        end
      end
      ST_RUN: begin
        if (sleep_request_q && bus_idle) begin
          state_d = ST_SLEEP;                              // [RULE_11]
        end
      end
      ST_INIT: begin
        if (!config_mode_request_q) begin
          state_d = ST_RESYNC;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          wake_ev_d = 1'b1;                                // [RULE_10]
          state_d   = ST_RESYNC;
        end else if (!sleep_request_q) begin
          state_d = ST_RESYNC;                             // [RULE_14]
        end
      end
      default: state_d = ST_INIT;
    endcase
    if (state_d != ST_RESYNC) begin
      rec_cnt_d = 4'h0;
      run_cnt_d = 8'h00;
    end
    // Abort at once; sync drops and ack follows on the next edge
    if (config_mode_request_q) begin
      state_d = ST_INIT;                                   // [RULE_15]
    end
  end

  // Error counters live elsewhere and are not touched here [RULE_18]
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q   <= ST_INIT;
      rec_cnt_q <= 4'h0;
      run_cnt_q <= 8'h00;
      wake_ev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      rec_cnt_q <= rec_cnt_d;
      run_cnt_q <= run_cnt_d;
      wake_ev_q <= wake_ev_d;
    end
  end

  // Stamp timer and two-beat store into the buffer top bytes
  always_comb begin
    stamp_d   = stamp_q;
    beat_d    = 1'b0;
    lo_byte_d = lo_byte_q;
    st_we_d   = 1'b0;
    st_addr_d = st_addr_q;
    st_data_d = st_data_q;
    // Clear on the disabling edge too, so no stale count is left behind
    if (!time_q || !time_d) begin
      stamp_d = STAMP_RST;                                 // [RULE_08]
    end else if (bit_tick_in) begin
      stamp_d = stamp_q + 16'h0001;                        // [RULE_06]
    end
    if (beat_q) begin
      st_we_d   = 1'b1;
      st_addr_d = STAMP_LO_OFS;
      st_data_d = lo_byte_q;
    end else if (msg_ack_in && time_q) begin
      st_we_d   = 1'b1;                                    // [RULE_07]
      st_addr_d = STAMP_HI_OFS;
      st_data_d = stamp_q[15:8];
      lo_byte_d = stamp_q[7:0];
      beat_d    = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stamp_q   <= STAMP_RST;
      beat_q    <= 1'b0;
      lo_byte_q <= 8'h00;
      st_we_q   <= 1'b0;
      st_addr_q <= 4'h0;
      st_data_q <= 8'h00;
    end else begin
      stamp_q   <= stamp_d;
      beat_q    <= beat_d;
      lo_byte_q <= lo_byte_d;
      st_we_q   <= st_we_d;
      st_addr_q <= st_addr_d;
      st_data_q <= st_data_d;
    end
  end

  // Read port and registered transmit pin
  always_comb begin
    rdata_d = 8'h00;
    txpin_d = halt_tx ? 1'b1 : tx_bit_in;                  // [RULE_24]
    if (reg_rd_in && bif_run) begin
      case (reg_addr_in)
        ADDR_MODE: begin
          rdata_d[B_RECEIVED_FRAME_FLAG] = received_frame_flag_q;
          rdata_d[B_RECEIVER_ACTIVE] = rx_busy_in && !init_mode;     // [RULE_03]
          rdata_d[B_STOPW] = stopw_q;
          rdata_d[B_SYNC]  = (state_q == ST_RUN);          // [RULE_05]
          rdata_d[B_TIME]  = time_q;
          rdata_d[B_WAKE]  = wake_q;
          rdata_d[B_SLEEP_REQUEST] = sleep_request_q;
          rdata_d[B_INIT]  = config_mode_request_q;
        end
        ADDR_ACK: begin
          rdata_d[B_SLEEP_ACK] = slp_ack;
          rdata_d[B_INIAK] = cfg_ack;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      txpin_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      txpin_q <= txpin_d;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_received_frame_flag_set;
    rx_frame_done_in && !init_mode |=> received_frame_flag_q;
  endproperty
  a_received_frame_flag_set: assert property (p_received_frame_flag_set) // [RULE_01]
    else $error("frame flag not set");

  property p_received_frame_flag_w0;
    wr_mode && !reg_wdata_in[B_RECEIVED_FRAME_FLAG] && received_frame_flag_q && !init_mode
      |=> received_frame_flag_q;
  endproperty
  a_received_frame_flag_w0: assert property (p_received_frame_flag_w0) // [RULE_02]
    else $error("zero write cleared frame flag");

  property p_stamp_zero;
    !time_q |-> stamp_q == STAMP_RST;
  endproperty
  a_stamp_zero: assert property (p_stamp_zero) // [RULE_08]
    else $error("stamp not zero while disabled");

  property p_init_time;
    init_mode |=> !time_q;
  endproperty
  a_init_time: assert property (p_init_time) // [RULE_09]
    else $error("stamp enable set in init");

  property p_slp_refuse;
    wr_mode && reg_wdata_in[B_SLEEP_REQUEST] && !sleep_request_q && wake_flag_in
      |=> !sleep_request_q;
  endproperty
  a_slp_refuse: assert property (p_slp_refuse) // [RULE_13]
    else $error("sleep request set with wake flag");

  property p_sleep_idle;
    $rose(slp_ack) |-> $past(bus_idle);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) // [RULE_11]
    else $error("sleep entered with bus busy");

  property p_init_ack;
    config_mode_request_q && !cfg_ack |=> cfg_ack && abort_xfer_out;
  endproperty
  a_init_ack: assert property (p_init_ack) // [RULE_15]
    else $error("init not acknowledged in one cycle");

  property p_config_mode_request_hold;
    config_mode_request_q && !cfg_ack |=> config_mode_request_q;
  endproperty
  a_config_mode_request_hold: assert property (p_config_mode_request_hold) // [RULE_23]
    else $error("init request cleared before ack");

  property p_txpin;
    config_mode_request_q |=> transmit_pin_out;
  endproperty
  a_txpin: assert property (p_txpin) // [RULE_24]
    else $error("transmit pin not recessive");

  property p_stamp_beats;
    msg_ack_in && time_q && !beat_q |=> stamp_we_out
      && stamp_addr_out == STAMP_HI_OFS ##1 stamp_we_out
      && stamp_addr_out == STAMP_LO_OFS;
  endproperty
  a_stamp_beats: assert property (p_stamp_beats) // [RULE_07]
    else $error("stamp store sequence wrong");

  c_sleep: cover property (sleep_request_q ##[1:20] slp_ack);
  c_sync:  cover property ($rose(state_q == ST_RUN));
  c_wake:  cover property (wake_event_out);
  c_stamp: cover property (stamp_we_out ##1 stamp_we_out);
endmodule

/* rtl/cmc_pkg.sv */
// Constants and types of the CAN mode control block
package cmc_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_ACK  = 4'h1;
  // Bit positions in the mode control register
  localparam int unsigned B_RECEIVED_FRAME_FLAG = 7;
  localparam int unsigned B_RECEIVER_ACTIVE = 6;
  localparam int unsigned B_STOPW = 5;
  localparam int unsigned B_SYNC  = 4;
  localparam int unsigned B_TIME  = 3;
  localparam int unsigned B_WAKE  = 2;
  localparam int unsigned B_SLEEP_REQUEST = 1;
  localparam int unsigned B_INIT  = 0;
  // Bit positions in the acknowledge status register
  localparam int unsigned B_SLEEP_ACK = 1;
  localparam int unsigned B_INIAK = 0;
  // Reset value: initialization requested
  localparam logic [7:0] MODE_RST = 8'h01;
  // Resynchronization figures
  localparam logic [3:0] REC_RUN   = 4'hB;
  localparam logic [7:0] BOFF_RUNS = 8'h80;
  // Stamp byte offsets inside a message buffer
  localparam logic [3:0] STAMP_HI_OFS = 4'hE;
  localparam logic [3:0] STAMP_LO_OFS = 4'hF;
  localparam logic [15:0] STAMP_RST   = 16'h0000;
  // Operating state, one-hot
  typedef enum logic [3:0] {
    ST_RESYNC = 4'h1,
    ST_RUN    = 4'h2,
    ST_INIT   = 4'h4,
    ST_SLEEP  = 4'h8
  } cmc_state_t;
endpackage
